// file: core/csf_evt_unit.sv
// sticky event status, mask and interrupt level
`timescale 1ns/1ps
`default_nettype none
module csf_evt_unit import csf_pkg::*; (
   input wire logic clk_i, // cpu clock
   input wire logic rst_i, // async reset, active high
   csf_link_if.evu ev // events in, status out
);
   logic [CSF_NEV-1:0] st_q, st_d, mk_q, mk_d;
   logic irq_q, irq_d;
   always_comb begin
      mk_d = ev.mask_wr ? ev.mask_wdata : mk_q;
      // a new event wins over the read clear
      st_d = (ev.rd_clr ? '0 : st_q) | ev.evt;
      irq_d = |(st_d & mk_d);
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= CSF_RST_EV;
         mk_q <= CSF_RST_EV;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mk_q <= mk_d;
         irq_q <= irq_d;
      end
   end
   assign ev.status = st_q;
   assign ev.mask = mk_q;
   assign ev.irq = irq_q;
endmodule // csf_evt_unit
`default_nettype wire

// file: core/csf_flag_eval.sv
// evaluates alu result flags from operands and result
`timescale 1ns/1ps
`default_nettype none
module csf_flag_eval import csf_pkg::*; #(
   parameter int W = CSF_DW
) (
   input wire logic [W-1:0] a_i, // first operand
   input wire logic [W-1:0] b_i, // second operand
   input wire logic [W-1:0] res_i, // alu result
   input wire logic sub_i, // operation was a subtract
   input wire logic cout_i, // carry out of result msb
   csf_link_if.eval fl // flag results
);
   // refuse widths with no room for a sign bit
   if (W < 2) begin : g_bad_width
      $error("csf_flag_eval: width below 2");
   end
   always_comb begin
      fl.neg = res_i[W-1];
      if (sub_i) begin
         fl.ovf = (a_i[W-1] != b_i[W-1]) && (res_i[W-1] != a_i[W-1]);
      end else begin
         fl.ovf = (a_i[W-1] == b_i[W-1]) && (res_i[W-1] != a_i[W-1]);
      end
      fl.zero = (res_i == '0);
      fl.carry = cout_i;
   end
endmodule // csf_flag_eval
`default_nettype wire

// file: core/csf_link_if.sv
// signals between the status core, flag evaluator and event unit
`timescale 1ns/1ps
`default_nettype none
interface csf_link_if;
   import csf_pkg::*;
   logic neg;
   logic ovf;
   logic zero;
   logic carry;
   logic [CSF_NEV-1:0] evt;
   logic rd_clr;
   logic mask_wr;
   logic [CSF_NEV-1:0] mask_wdata;
   logic [CSF_NEV-1:0] status;
   logic [CSF_NEV-1:0] mask;
   logic irq;
   modport eval (output neg, output ovf, output zero, output carry);
   modport evu (input evt, input rd_clr, input mask_wr, input mask_wdata,
      output status, output mask, output irq);
   modport core (input neg, input ovf, input zero, input carry,
      output evt, output rd_clr, output mask_wr, output mask_wdata,
      input status, input mask, input irq);
endinterface // csf_link_if
`default_nettype wire

// file: core/csf_pkg.sv
// constants shared by the cpu status flag block
// How it works
// - priority field sits in status bits 7..5, value equals level 0..7
// - field value 111 means level 7 and blocks all user interrupts
// - core control bit 3 joins above the field; set means field plus 8
// - core control bit 3 set blocks every user interrupt
// - nesting disable bit 15 makes the priority field ignore writes
// - status bit 4 is high while a hardware repeat loop runs
// - status bit 3 is set for a negative result, else cleared
// - status bit 2 is set on signed two's complement overflow, else cleared
// - status bit 1 stays set until a zero-affecting op gives non-zero or a status write clears it
// - status bit 0 is set on carry out of the result msb, else cleared
// - status writes change clip bits directly or clear both via combined bit
package csf_pkg;
   localparam int CSF_DW = 16;
   localparam int CSF_AW = 3;
   // register offsets
   localparam logic [2:0] CSF_OFF_STATUS = 3'h0;
   localparam logic [2:0] CSF_OFF_CORE = 3'h1;
   localparam logic [2:0] CSF_OFF_INTC1 = 3'h2;
   localparam logic [2:0] CSF_OFF_EVT = 3'h3;
   localparam logic [2:0] CSF_OFF_MASK = 3'h4;
   // status word field positions, then core bit 3 and intc1 bit 15
   localparam int CSF_BIT_C = 0;
   localparam int CSF_BIT_Z = 1;
   localparam int CSF_BIT_OV = 2;
   localparam int CSF_BIT_N = 3;
   localparam int CSF_BIT_RA = 4;
   localparam int CSF_BIT_IPL_LO = 5;
   localparam int CSF_BIT_IPL_HI = 7;
   localparam int CSF_BIT_SAB = 11;
   localparam int CSF_BIT_SB = 12;
   localparam int CSF_BIT_SA = 13;
   localparam int CSF_BIT_IPL3 = 3;
   localparam int CSF_BIT_NESTING_DISABLE = 15;
   // values after reset, and the top field level
   localparam logic [2:0] CSF_RST_IPL = 3'h0;
   localparam logic CSF_RST_BIT = 1'b0;
   localparam logic [15:0] CSF_RST_WORD = 16'h0000;
   localparam logic [2:0] CSF_LVL_TOP = 3'h7;
   // event bits
   localparam int CSF_NEV = 4;
   localparam int CSF_EV_OV = 0;
   localparam int CSF_EV_SA = 1;
   localparam int CSF_EV_SB = 2;
   localparam int CSF_EV_LOOP = 3;
   localparam logic [3:0] CSF_RST_EV = 4'h0;
endpackage

// file: core/csf_status.sv
// cpu status word with priority, loop, alu and accumulator clip flags
`timescale 1ns/1ps
`default_nettype none
module csf_status import csf_pkg::*; (
   input wire logic clk_i, // cpu clock
   input wire logic rst_i, // async reset, active high
   input wire logic [CSF_AW-1:0] reg_addr_i, // register offset
   input wire logic [15:0] reg_wdata_i, // write data
   input wire logic reg_wr_i, // write strobe
   input wire logic reg_rd_i, // read strobe
   output logic [15:0] reg_rdata_o, // read data, cycle after strobe
   input wire logic alu_upd_i, // op updates negative, overflow, carry
   input wire logic alu_zupd_i, // op updates zero flag
   input wire logic alu_sub_i, // op is a subtract
   input wire logic [CSF_DW-1:0] alu_a_i, // first operand
   input wire logic [CSF_DW-1:0] alu_b_i, // second operand
   input wire logic [CSF_DW-1:0] alu_res_i, // alu result
   input wire logic alu_cout_i, // carry out of result msb
   input wire logic loop_busy_i, // repeat loop executing
   input wire logic clip_a_set_i, // accumulator a saturated
   input wire logic clip_b_set_i, // accumulator b saturated
   output logic [3:0] cpu_priority_level_o, // effective level 0..15
   output logic user_irq_block_o, // user interrupts blocked
   output logic loop_busy_flag_o, // repeat loop status bit
   output logic [3:0] alu_flags_o, // negative, overflow, zero, carry
   output logic acc_clip_a_o, // accumulator a clip bit
   output logic acc_clip_b_o, // accumulator b clip bit
   output logic irq_o // unmasked event pending
);
   csf_link_if lnk ();

   csf_flag_eval #(
      .W(CSF_DW)
   ) u_eval (
      .a_i(alu_a_i),
      .b_i(alu_b_i),
      .res_i(alu_res_i),
      .sub_i(alu_sub_i),
      .cout_i(alu_cout_i),
      .fl(lnk.eval)
   );

   csf_evt_unit u_evt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ev(lnk.evu)
   );

   logic [2:0] ipl_q, ipl_d;
   logic ra_q, ra_d;
   logic n_q, n_d;
   logic ov_q, ov_d;
   logic z_q, z_d;
   logic c_q, c_d;
   logic sa_q, sa_d;
   logic sb_q, sb_d;
   logic ipl3_q, ipl3_d;
   logic nst_q, nst_d;
   logic [3:0] lvl_q, lvl_d;
   logic blk_q, blk_d;
   logic [15:0] rdata_q, rdata_d;
   logic sw_st, sw_core, sw_intc;
   logic [15:0] st_word;

   always_comb begin
      sw_st = reg_wr_i && (reg_addr_i == CSF_OFF_STATUS);
      sw_core = reg_wr_i && (reg_addr_i == CSF_OFF_CORE);
      sw_intc = reg_wr_i && (reg_addr_i == CSF_OFF_INTC1);
      ipl_d = ipl_q;
      n_d = n_q;
      ov_d = ov_q;
      z_d = z_q;
      c_d = c_q;
      sa_d = sa_q;
      sb_d = sb_q;
      ipl3_d = ipl3_q;
      nst_d = nst_q;
      // field writable unless nesting is disabled
      if (sw_st && !nst_q) begin
         ipl_d = reg_wdata_i[CSF_BIT_IPL_HI:CSF_BIT_IPL_LO];
      end
      if (sw_st) begin
         n_d = reg_wdata_i[CSF_BIT_N];
         ov_d = reg_wdata_i[CSF_BIT_OV];
         z_d = reg_wdata_i[CSF_BIT_Z];
         c_d = reg_wdata_i[CSF_BIT_C];
         // direct write, or combined bit low clears both
         sa_d = reg_wdata_i[CSF_BIT_SA] & reg_wdata_i[CSF_BIT_SAB];
         sb_d = reg_wdata_i[CSF_BIT_SB] & reg_wdata_i[CSF_BIT_SAB];
      end
      // hardware set wins over a racing software write
      if (clip_a_set_i) begin
         sa_d = 1'b1;
      end
      if (clip_b_set_i) begin
         sb_d = 1'b1;
      end
      // alu owns the flags over software
      if (alu_upd_i) begin
         n_d = lnk.neg;
         ov_d = lnk.ovf;
         c_d = lnk.carry;
      end
      if (alu_zupd_i) begin
         z_d = lnk.zero;
      end
      ra_d = loop_busy_i;
      if (sw_core) begin
         ipl3_d = reg_wdata_i[CSF_BIT_IPL3];
      end
      if (sw_intc) begin
         nst_d = reg_wdata_i[CSF_BIT_NESTING_DISABLE];
      end
      lvl_d = {ipl3_d, ipl_d};
      blk_d = ipl3_d || (ipl_d == CSF_LVL_TOP);
   end

   always_comb begin
      st_word = 16'h0000;
      st_word[CSF_BIT_C] = c_q;
      st_word[CSF_BIT_Z] = z_q;
      st_word[CSF_BIT_OV] = ov_q;
      st_word[CSF_BIT_N] = n_q;
      st_word[CSF_BIT_RA] = ra_q;
      st_word[CSF_BIT_IPL_HI:CSF_BIT_IPL_LO] = ipl_q;
      st_word[CSF_BIT_SAB] = sa_q | sb_q;
      st_word[CSF_BIT_SB] = sb_q;
      st_word[CSF_BIT_SA] = sa_q;
      rdata_d = 16'h0000;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            CSF_OFF_STATUS: rdata_d = st_word;
            CSF_OFF_CORE: rdata_d[CSF_BIT_IPL3] = ipl3_q;
            CSF_OFF_INTC1: rdata_d[CSF_BIT_NESTING_DISABLE] = nst_q;
            CSF_OFF_EVT: rdata_d[CSF_NEV-1:0] = lnk.status;
            CSF_OFF_MASK: rdata_d[CSF_NEV-1:0] = lnk.mask;
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_comb begin
      lnk.evt = '0;
      lnk.evt[CSF_EV_OV] = alu_upd_i && lnk.ovf;
      lnk.evt[CSF_EV_SA] = clip_a_set_i && !sa_q;
      lnk.evt[CSF_EV_SB] = clip_b_set_i && !sb_q;
      lnk.evt[CSF_EV_LOOP] = ra_q && !loop_busy_i;
      lnk.rd_clr = reg_rd_i && (reg_addr_i == CSF_OFF_EVT);
      lnk.mask_wr = reg_wr_i && (reg_addr_i == CSF_OFF_MASK);
      lnk.mask_wdata = reg_wdata_i[CSF_NEV-1:0];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ipl_q <= CSF_RST_IPL;
         ra_q <= CSF_RST_BIT;
         n_q <= CSF_RST_BIT;
         ov_q <= CSF_RST_BIT;
         z_q <= CSF_RST_BIT;
         c_q <= CSF_RST_BIT;
         sa_q <= CSF_RST_BIT;
         sb_q <= CSF_RST_BIT;
         ipl3_q <= CSF_RST_BIT;
         nst_q <= CSF_RST_BIT;
         lvl_q <= 4'h0;
         blk_q <= 1'b0;
         rdata_q <= CSF_RST_WORD;
      end else begin
         ipl_q <= ipl_d;
         ra_q <= ra_d;
         n_q <= n_d;
         ov_q <= ov_d;
         z_q <= z_d;
         c_q <= c_d;
         sa_q <= sa_d;
         sb_q <= sb_d;
         ipl3_q <= ipl3_d;
         nst_q <= nst_d;
         lvl_q <= lvl_d;
         blk_q <= blk_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign cpu_priority_level_o = lvl_q;
   assign user_irq_block_o = blk_q;
   assign loop_busy_flag_o = ra_q;
   assign alu_flags_o = {n_q, ov_q, z_q, c_q};
   assign acc_clip_a_o = sa_q;
   assign acc_clip_b_o = sb_q;
   assign irq_o = lnk.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_ipl_field_write: assert property (
      sw_st && !nst_q |=> ipl_q == $past(reg_wdata_i[7:5]))
      else $error("priority field did not take written value");
   chk_level7_block: assert property (
      ipl_q == 3'h7 |-> user_irq_block_o)
      else $error("level 7 did not block user interrupts");
   chk_level_join: assert property (
      cpu_priority_level_o == {ipl3_q, ipl_q})
      else $error("effective level not field plus fourth bit");
   chk_ipl3_block: assert property (
      ipl3_q |-> user_irq_block_o)
      else $error("fourth priority bit did not block");
   chk_nest_lock: assert property (
      sw_st && nst_q |=> ipl_q == $past(ipl_q))
      else $error("priority field changed while nesting disabled");
   chk_loop_flag: assert property (
      ##1 loop_busy_flag_o == $past(loop_busy_i))
      else $error("loop flag does not follow loop busy");
   chk_neg_flag: assert property (
      alu_upd_i |=> alu_flags_o[3] == $past(alu_res_i[15]))
      else $error("negative flag wrong");
   chk_ovf_add: assert property (
      alu_upd_i && !alu_sub_i && (alu_a_i[15] == alu_b_i[15])
      && (alu_res_i[15] != alu_a_i[15]) |=> alu_flags_o[2])
      else $error("overflow flag missed on add");
   chk_zero_clear: assert property (
      alu_zupd_i && (alu_res_i != 16'h0000) |=> !alu_flags_o[1])
      else $error("zero flag not cleared on non-zero result");
   chk_zero_hold: assert property (
      z_q && !alu_zupd_i && !sw_st |=> z_q)
      else $error("zero flag lost without an update");
   chk_carry_flag: assert property (
      alu_upd_i |=> alu_flags_o[0] == $past(alu_cout_i))
      else $error("carry flag wrong");
   chk_clip_clear: assert property (
      sw_st && !reg_wdata_i[11] && !clip_a_set_i && !clip_b_set_i
      |=> !acc_clip_a_o && !acc_clip_b_o)
      else $error("combined clip clear did not clear both");
endmodule // csf_status
`default_nettype wire

// file: dv/csf_alu_model.sv
// far-side alu model presenting one operation per request
`timescale 1ns/1ps
`default_nettype none
module csf_alu_model import csf_pkg::*; (
   input wire logic go_i, // present an operation this cycle
   input wire logic zop_i, // operation affects the zero flag
   input wire logic sub_i, // subtract instead of add
   input wire logic [CSF_DW-1:0] a_i, // first operand
   input wire logic [CSF_DW-1:0] b_i, // second operand
   output logic upd_o, // update strobe
   output logic zupd_o, // zero update strobe
   output logic sub_o, // subtract flag
   output logic [CSF_DW-1:0] a_o, // first operand out
   output logic [CSF_DW-1:0] b_o, // second operand out
   output logic [CSF_DW-1:0] res_o, // result
   output logic cout_o // carry out of result msb
);
   logic [CSF_DW:0] sum;
   // idle operand, subtract, result and carry outputs show inverted data, strobes stay low, so nothing stale looks valid
   always_comb begin
      if (sub_i) begin
         sum = {1'b0, a_i} + {1'b0, ~b_i} + 17'h00001;
      end else begin
         sum = {1'b0, a_i} + {1'b0, b_i};
      end
      upd_o = go_i;
      zupd_o = go_i & zop_i;
      sub_o = go_i ? sub_i : ~sub_i;
      a_o = go_i ? a_i : ~a_i;
      b_o = go_i ? b_i : ~b_i;
      res_o = go_i ? sum[CSF_DW-1:0] : ~sum[CSF_DW-1:0];
      cout_o = go_i ? sum[CSF_DW] : ~sum[CSF_DW];
   end
endmodule // csf_alu_model
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the cpu status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top import csf_pkg::*;;
   typedef struct {logic [15:0] a; logic [15:0] b; logic sub; logic zop;
      logic [3:0] flg;} csf_row_t;
   logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0;
   logic zop = 1'b0, sub = 1'b0, loop = 1'b0, ca = 1'b0, cb = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wd = 16'h0000, a = 16'h0000, b = 16'h0000, rdata;
   logic upd, zupd, msub, cout, blk, lflag, clpa, clpb, irq;
   logic [15:0] ma, mb, res;
   logic [3:0] lvl, flags;
   int bad_count = 0, total_checks = 0;
   csf_row_t rows [6] = '{
      '{16'h7FFF, 16'h0001, 1'b0, 1'b1, 4'hC},
      '{16'hFFFF, 16'h0001, 1'b0, 1'b1, 4'h3},
      '{16'h0001, 16'h0001, 1'b0, 1'b0, 4'h2},
      '{16'h8000, 16'h0001, 1'b1, 1'b1, 4'h5},
      '{16'h0005, 16'h0007, 1'b1, 1'b1, 4'h8},
      '{16'h0003, 16'h0004, 1'b0, 1'b1, 4'h0}};
   always #12.5 clk_i = ~clk_i;
   csf_alu_model csf_alu_model_inst (.go_i(go), .zop_i(zop), .sub_i(sub),
      .a_i(a), .b_i(b), .upd_o(upd), .zupd_o(zupd), .sub_o(msub),
      .a_o(ma), .b_o(mb), .res_o(res), .cout_o(cout));
   csf_status csf_status_inst (.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .alu_upd_i(upd), .alu_zupd_i(zupd),
      .alu_sub_i(msub), .alu_a_i(ma), .alu_b_i(mb), .alu_res_i(res),
      .alu_cout_i(cout), .loop_busy_i(loop), .clip_a_set_i(ca),
      .clip_b_set_i(cb), .cpu_priority_level_o(lvl),
      .user_irq_block_o(blk), .loop_busy_flag_o(lflag),
      .alu_flags_o(flags), .acc_clip_a_o(clpa), .acc_clip_b_o(clpb),
      .irq_o(irq));
   task automatic chk(input string nm, input logic [15:0] exp,
      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [2:0] ad, input logic [15:0] d);
      @(posedge clk_i);
      addr <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [2:0] ad, input logic [15:0] exp,
      input string nm);
      @(posedge clk_i);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk(nm, exp, rdata);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #(25 * 4000);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         // reset values, unmapped offset reads 0
         rd_reg(i[2:0], 16'h0000, "reset value");
      end
      chk("level after reset", 16'h0000, {11'h000, blk, lvl});
      wr_reg(3'h6, 16'hFFFF);
      rd_reg(3'h6, 16'h0000, "unmapped");
      foreach (rows[i]) begin
         @(posedge clk_i);
         {a, b, sub, zop, go} <= {rows[i].a, rows[i].b, rows[i].sub,
            rows[i].zop, 1'b1};
         @(posedge clk_i);
         go <= 1'b0;
         #1;
         chk("flg", 16'(rows[i].flg), 16'(flags));
      end
      chk("masked irq", 16'h0000, {15'h0000, irq});
      wr_reg(CSF_OFF_MASK, 16'h000F);
      chk("unmasked irq", 16'h0001, {15'h0000, irq});
      rd_reg(CSF_OFF_EVT, 16'h0001, "overflow event");
      chk("irq after clear", 16'h0000, {15'h0000, irq});
      for (int c = 0; c < 2; c++) begin
         for (int f = 0; f < 8; f++) begin
            wr_reg(CSF_OFF_CORE, 16'(c << 3));
            wr_reg(CSF_OFF_STATUS, 16'(f << 5));
            chk("level", 16'(c * 8 + f), {12'h000, lvl});
            chk("user block", 16'(f == 7 || c == 1), 16'(blk));
            rd_reg(CSF_OFF_STATUS, 16'(f << 5), "field readback");
         end
      end
      wr_reg(CSF_OFF_CORE, 16'h0000);
      wr_reg(CSF_OFF_STATUS, 16'h0060);
      wr_reg(CSF_OFF_INTC1, 16'h8000);
      wr_reg(CSF_OFF_STATUS, 16'h00A1);
      chk("locked level", 16'h0003, {12'h000, lvl});
      rd_reg(CSF_OFF_STATUS, 16'h0061, "locked field");
      wr_reg(CSF_OFF_INTC1, 16'h0000);
      wr_reg(CSF_OFF_STATUS, 16'h0000);
      @(posedge clk_i);
      loop <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk("loop flag on", 16'h0001, {15'h0000, lflag});
      rd_reg(CSF_OFF_STATUS, 16'h0010, "loop bit");
      @(posedge clk_i);
      loop <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk("loop flag off", 16'h0000, {15'h0000, lflag});
      chk("loop end irq", 16'h0001, {15'h0000, irq});
      rd_reg(CSF_OFF_EVT, 16'h0008, "loop end event");
      @(posedge clk_i);
      ca <= 1'b1;
      @(posedge clk_i);
      ca <= 1'b0;
      #1;
      chk("clip a set", 16'h0002, {14'h0000, clpa, clpb});
      rd_reg(CSF_OFF_STATUS, 16'h2800, "clip readback");
      // read data must fall back to zero one cycle later
      @(posedge clk_i);
      #1;
      chk("read data stands one cycle", 16'h0000, rdata);
      rd_reg(CSF_OFF_EVT, 16'h0002, "clip event");
      wr_reg(CSF_OFF_STATUS, 16'h0000);
      chk("combined clear", 16'h0000, {14'h0000, clpa, clpb});
      wr_reg(CSF_OFF_STATUS, 16'h3800);
      chk("direct set", 16'h0003, {14'h0000, clpa, clpb});
      wr_reg(CSF_OFF_STATUS, 16'h1800);
      chk("direct mixed", 16'h0001, {14'h0000, clpa, clpb});
      // reset again in mid-run with clip b still set
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("mid reset outputs", 16'h0000, {lvl, flags, 6'h00, clpa, clpb});
      chk("mid reset block", 16'h0000, {14'h0000, blk, irq});
      rd_reg(CSF_OFF_STATUS, 16'h0000, "mid reset status");
      rd_reg(CSF_OFF_MASK, 16'h0000, "mid reset mask");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
